// *** rtl/tot_pkg.sv ***
package tot_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Control field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_TRIG_BIT = 4;
  localparam int CTRL_EDGE_LSB = 5;

  // Status field positions
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_PULSE_BIT  = 1;
  localparam int STAT_TOGGLE_BIT = 2;
  localparam int STAT_ARM_BIT    = 3;

  // Mode codes
  localparam logic [2:0] MODE_EXT     = 3'h2;
  localparam logic [2:0] MODE_ONESHOT = 3'h3;
  localparam logic [2:0] MODE_PWM     = 3'h4;

  // Counter values
  localparam logic [15:0] CNT_IDLE  = 16'hffff;
  localparam logic [15:0] CNT_CLEAR = 16'h0000;

  // Reset values
  localparam logic [2:0]  MODE_RST    = 3'h0;
  localparam logic [1:0]  EDGE_RST    = 2'h1;
  localparam logic [15:0] PERIOD_RST  = 16'h0000;
  localparam logic [15:0] DUTY_RST    = 16'h0000;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // Trigger edge selection codes
  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

endpackage

// *** rtl/tot_trig_sync.sv ***
`timescale 1ns/1ps
module tot_trig_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig_in,
  output logic      rise,
  output logic      fall
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= trig_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= (stage2 == stage3) && stage3 && !level;
      fall <= (stage2 == stage3) && !stage3 && level;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

endmodule

// *** rtl/tot_timer.sv ***
`timescale 1ns/1ps
// Operation
// - Buffered modes load shadows at start; later counter clears load them only after a duty write.
// - Duty zero gives inactive output; duty match still fires with period FFFFH.
// - Duty equal period plus one gives constant active output.
// - Trigger after duty match clears counter and asserts pulse output.
// - Trigger just before duty match suppresses it and keeps output active.
// - Trigger after period match clears counter and keeps counting.
// - Trigger just before period match suppresses it and asserts output.
// - Duty match pulse appears in the cycle of the match itself.
// - Mode code 011 selects one-shot, code 100 selects PWM.
// - One-shot waits for trigger, then counter goes FFFFH to 0000H.
// - After one-shot pulse counter loads FFFFH and waits; retriggers ignored.
// - One-shot delay is duty clocks, width period minus duty plus one.
// - In one-shot, toggle output is active exactly while counting.
// - Trigger is a valid pin edge or a software trigger write.
// - One-shot compare writes take effect immediately.
// - PWM start clears counter to 0000H; toggle halves the PWM rate.
// - PWM cycle is period plus one; period match fires at the clear.
// - Counter readback returns the live counter without disturbing it.
// - Trigger during external-trigger counting clears counter and restarts.
module tot_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_in,
  output logic             pulse_out,
  output logic             toggle_out,
  output logic             period_match_irq,
  output logic             duty_match_irq
);

  logic        run_enable;
  logic [2:0]  op_mode_sel;
  logic [1:0]  trigger_edge_cfg;
  logic        soft_trigger;
  logic [15:0] period_compare_reg;
  logic [15:0] duty_compare_reg;
  logic [15:0] period_shadow;
  logic [15:0] duty_shadow;
  logic        shadow_armed;
  logic [15:0] count;
  logic        counting;
  logic        pin_rise;
  logic        pin_fall;
  logic        trigger;
  logic        access;
  logic        wr_ctrl;
  logic        wr_period;
  logic        wr_duty;

  logic [15:0] next_count;
  logic        next_counting;
  logic        cleared;
  logic        period_hit;
  logic        retrigger;
  logic        load_shadow;
  logic [15:0] cmp_period;
  logic [15:0] cmp_duty;
  logic        next_pulse;
  logic        next_toggle;
  logic        next_duty_irq;
  logic [31:0] next_rdata;
  logic        next_err;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  function automatic logic count_hits(input logic [15:0] c, input logic [15:0] v);
    count_hits = (c == v);
  endfunction

  // Pin edges count once the last two sync stages agree
  tot_trig_sync u_trig_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .trig_in (trig_in),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // Bus side: one wait-free access phase, answer registered at setup
  assign access    = psel && penable && pready;
  assign wr_ctrl   = access && pwrite && addr_is(paddr, tot_pkg::CTRL_OFS);
  assign wr_period = access && pwrite && addr_is(paddr, tot_pkg::PERIOD_OFS);
  assign wr_duty   = access && pwrite && addr_is(paddr, tot_pkg::DUTY_OFS);

  always_comb begin
    next_err   = 1'b0;
    next_rdata = tot_pkg::RDATA_RST;
    unique case (paddr)
      tot_pkg::CTRL_OFS: begin
        next_rdata[tot_pkg::CTRL_RUN_BIT]                       = run_enable;
        next_rdata[tot_pkg::CTRL_MODE_LSB +: 3]                 = op_mode_sel;
        next_rdata[tot_pkg::CTRL_EDGE_LSB +: 2]                 = trigger_edge_cfg;
      end
      tot_pkg::PERIOD_OFS: next_rdata[15:0] = period_compare_reg;
      tot_pkg::DUTY_OFS:   next_rdata[15:0] = duty_compare_reg;
      tot_pkg::COUNT_OFS:  next_rdata[15:0] = count;
      tot_pkg::STATUS_OFS: begin
        next_rdata[tot_pkg::STAT_RUN_BIT]    = counting;
        next_rdata[tot_pkg::STAT_PULSE_BIT]  = pulse_out;
        next_rdata[tot_pkg::STAT_TOGGLE_BIT] = toggle_out;
        next_rdata[tot_pkg::STAT_ARM_BIT]    = shadow_armed;
      end
      // Unmapped words answer with an error and read as zero
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= tot_pkg::RDATA_RST;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? tot_pkg::RDATA_RST : next_rdata;
        pslverr <= next_err;
      end
    end
  end

  // Software trigger is a one-cycle strobe and reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_trigger <= 1'b0;
    end else begin
      soft_trigger <= wr_ctrl && pwdata[tot_pkg::CTRL_TRIG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable       <= 1'b0;
      op_mode_sel      <= tot_pkg::MODE_RST;
      trigger_edge_cfg <= tot_pkg::EDGE_RST;
    end else begin
      if (wr_ctrl) begin
        run_enable       <= pwdata[tot_pkg::CTRL_RUN_BIT];
        op_mode_sel      <= pwdata[tot_pkg::CTRL_MODE_LSB +: 3];
        trigger_edge_cfg <= pwdata[tot_pkg::CTRL_EDGE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_compare_reg <= tot_pkg::PERIOD_RST;
    end else if (wr_period) begin
      period_compare_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_compare_reg <= tot_pkg::DUTY_RST;
    end else if (wr_duty) begin
      duty_compare_reg <= pwdata[15:0];
    end
  end

  always_comb begin
    // Edge select none leaves only the software strobe
    unique case (trigger_edge_cfg)
      tot_pkg::EDGE_NONE: trigger = soft_trigger;
      tot_pkg::EDGE_RISE: trigger = soft_trigger || pin_rise;
      tot_pkg::EDGE_FALL: trigger = soft_trigger || pin_fall;
      tot_pkg::EDGE_BOTH: trigger = soft_trigger || pin_rise || pin_fall;
    endcase
  end

  // Counter sequencing per mode
  // Count clock is pclk itself; there is no prescaler here
  always_comb begin
    next_count    = count;
    next_counting = counting;
    cleared       = 1'b0;
    period_hit    = 1'b0;
    retrigger     = 1'b0;
    if (!run_enable) begin
      next_count    = tot_pkg::CNT_IDLE;
      next_counting = 1'b0;
    end else begin
      unique case (op_mode_sel)
        tot_pkg::MODE_PWM: begin
          if (!counting) begin
            next_count    = tot_pkg::CNT_CLEAR;
            next_counting = 1'b1;
            cleared       = 1'b1;
          end else if (count_hits(count, period_shadow)) begin
            next_count = tot_pkg::CNT_CLEAR;
            cleared    = 1'b1;
            period_hit = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        tot_pkg::MODE_EXT: begin
          if (trigger) begin
            // Restart wins over any match in the same cycle
            next_count    = tot_pkg::CNT_CLEAR;
            next_counting = 1'b1;
            cleared       = 1'b1;
            retrigger     = counting;
          end else if (counting && count_hits(count, period_shadow)) begin
            next_count = tot_pkg::CNT_CLEAR;
            cleared    = 1'b1;
            period_hit = 1'b1;
          end else if (counting) begin
            next_count = count + 16'h0001;
          end
        end
        tot_pkg::MODE_ONESHOT: begin
          // Lowering the period compare below the count mid-pulse lets the count run on through FFFF
          if (!counting) begin
            if (trigger) begin
              next_count    = tot_pkg::CNT_CLEAR;
              next_counting = 1'b1;
            end
          end else if (count_hits(count, period_compare_reg)) begin
            next_count    = tot_pkg::CNT_IDLE;
            next_counting = 1'b0;
            period_hit    = 1'b1;
          end else begin
            // Triggers are not looked at while the pulse runs
            next_count = count + 16'h0001;
          end
        end
        // Codes outside the three counted modes hold the counter idle
        default: begin
          next_count    = tot_pkg::CNT_IDLE;
          next_counting = 1'b0;
        end
      endcase
    end
  end

  // First start always loads; later clears load only once armed by a duty write
  // A compare write in the transfer cycle itself misses it; the shadow takes the old value
  assign load_shadow = cleared && (shadow_armed || !counting);

  always_comb begin
    if (op_mode_sel == tot_pkg::MODE_ONESHOT) begin
      cmp_period = period_compare_reg;
      cmp_duty   = duty_compare_reg;
    end else begin
      cmp_period = load_shadow ? period_compare_reg : period_shadow;
      cmp_duty   = load_shadow ? duty_compare_reg : duty_shadow;
    end
  end

  // Outputs are computed from the next count so they line up with it
  always_comb begin
    next_toggle   = 1'b0;
    next_pulse    = 1'b0;
    next_duty_irq = next_counting && count_hits(next_count, cmp_duty) && !retrigger;
    unique case (op_mode_sel)
      tot_pkg::MODE_ONESHOT: begin
        next_pulse  = next_counting && (next_count >= cmp_duty)
                      && (next_count <= cmp_period);
        next_toggle = next_counting;
      end
      tot_pkg::MODE_PWM, tot_pkg::MODE_EXT: begin
        // Duty above period never matches, so the output stays active
        next_pulse  = next_counting && (next_count < cmp_duty);
        next_toggle = cleared ? !toggle_out : toggle_out;
      end
      default: next_duty_irq = 1'b0;
    endcase
    if (!run_enable) begin
      next_pulse    = 1'b0;
      next_toggle   = 1'b0;
      next_duty_irq = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= tot_pkg::CNT_IDLE;
      counting <= 1'b0;
    end else begin
      count    <= next_count;
      counting <= next_counting;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_shadow <= tot_pkg::PERIOD_RST;
      duty_shadow   <= tot_pkg::DUTY_RST;
    end else if (load_shadow) begin
      period_shadow <= period_compare_reg;
      duty_shadow   <= duty_compare_reg;
    end
  end

  // A duty write in the transfer cycle keeps the arm set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_armed <= 1'b0;
    end else if (wr_duty) begin
      shadow_armed <= 1'b1;
    end else if (load_shadow) begin
      shadow_armed <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_out  <= 1'b0;
      toggle_out <= 1'b0;
    end else begin
      pulse_out  <= next_pulse;
      toggle_out <= next_toggle;
    end
  end

  // Match strobes last one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_match_irq   <= 1'b0;
      period_match_irq <= 1'b0;
    end else begin
      duty_match_irq   <= next_duty_irq;
      period_match_irq <= period_hit;
    end
  end

endmodule

// *** sim/tot_trig_src.sv ***
`timescale 1ns/1ps
module tot_trig_src (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fire,
  output logic      trig_in
);
  logic [3:0] hold;

  // Held high long enough to pass the synchroniser and filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 4'h0;
    end else if (fire) begin
      hold <= 4'h8;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end

  assign trig_in = hold != 4'h0;
endmodule

// *** sim/tot_timer_chk.sv ***
`timescale 1ns/1ps
module tot_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pulse_out,
  input wire logic        toggle_out,
  input wire logic        period_match_irq,
  input wire logic        duty_match_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && pready;

  chk_pready_once: assert property (pready |=> !pready)
    else $error("pready held");
  chk_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer");
  chk_err_unmapped: assert property (acc && !pwrite && paddr > tot_pkg::STATUS_OFS
    |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  chk_err_mapped: assert property (acc && paddr <= tot_pkg::STATUS_OFS && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped error");
  chk_trig_reads0: assert property (
    acc && !pwrite && paddr == tot_pkg::CTRL_OFS |-> !prdata[tot_pkg::CTRL_TRIG_BIT])
    else $error("trigger bit read");
  chk_duty_irq_one: assert property (duty_match_irq |=> !duty_match_irq)
    else $error("duty pulse long");
  chk_period_irq_one: assert property (period_match_irq |=> !period_match_irq)
    else $error("period pulse long");
  chk_stop_idle: assert property (
    acc && pwrite && paddr == tot_pkg::CTRL_OFS && !pwdata[tot_pkg::CTRL_RUN_BIT] |-> ##2
    (!pulse_out && !toggle_out && !period_match_irq && !duty_match_irq) [*2])
    else $error("not idle after stop");
endmodule

bind tot_timer tot_timer_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .pulse_out, .toggle_out, .period_match_irq,
  .duty_match_irq);

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, trig_in, fire;
  logic        pulse_out, toggle_out, period_match_irq, duty_match_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] exp_q[$];
  int          failures, n_tests, p, d, n;

  tot_timer DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .trig_in, .pulse_out, .toggle_out, .period_match_irq,
    .duty_match_irq);
  tot_trig_src u_src (.pclk, .presetn, .fire, .trig_in);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task print_verdict();
    $display("Counts: %0d checks, %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask

  task bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  // Oldest note is matched against each read answer
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check(prdata, exp_q.pop_front());
    end
  end

  function logic [31:0] ctl(input logic [2:0] m, input logic r, input logic t);
    return {25'h0, tot_pkg::EDGE_RST, t, m, r};
  endfunction

  // Sampled on the falling edge, where registered outputs have settled
  task wait_on(input bit tg, input logic v, output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while ((tg ? toggle_out : pulse_out) !== v);
  endtask

  task pin();
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask

  task pwm_meas(input int dty, input int per);
    logic tg;
    wait_on(0, 0, n);
    wait_on(0, 1, n);
    tg = toggle_out;
    wait_on(0, 0, n);
    check(n, dty);
    check(duty_match_irq, 1'b1);
    wait_on(0, 1, n);
    check(n, per + 1 - dty);
    check(period_match_irq, 1'b1);
    check(toggle_out, !tg);
  endtask

  task flat(input int dv, input int eh, input int ei, input int per);
    int h;
    int di;
    h = 0;
    di = 0;
    bus(tot_pkg::DUTY_OFS, 1'b1, dv);
    repeat (2 * per + 4) @(negedge pclk);
    repeat (per + 1) begin
      @(negedge pclk);
      h += pulse_out;
      di += duty_match_irq;
    end
    check(h, eh);
    check(di, ei);
  endtask

  initial begin
    #200us;
    failures++;
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, fire, paddr, pwdata} = '0;
    failures = 0;
    n_tests = 0;
    void'($urandom(33814));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(tot_pkg::CTRL_OFS, ctl(tot_pkg::MODE_RST, 1'b0, 1'b0));
    rd(tot_pkg::COUNT_OFS, {16'h0, tot_pkg::CNT_IDLE});
    rd(tot_pkg::DUTY_OFS, 32'h0);
    rd(tot_pkg::STATUS_OFS, 32'h0);
    rd(8'h14, 32'h0);
    $display("Test reset done");
    p = $urandom_range(9, 5);
    d = $urandom_range(4, 1);
    bus(tot_pkg::PERIOD_OFS, 1'b1, p);
    bus(tot_pkg::DUTY_OFS, 1'b1, d);
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_PWM, 1'b1, 1'b0));
    pwm_meas(d, p);
    bus(tot_pkg::DUTY_OFS, 1'b1, d + 1);
    pwm_meas(d + 1, p);
    bus(tot_pkg::PERIOD_OFS, 1'b1, p + 3);
    pwm_meas(d + 1, p);
    bus(tot_pkg::DUTY_OFS, 1'b1, d + 1);
    pwm_meas(d + 1, p + 3);
    flat(0, 0, 1, p + 3);
    flat(p + 4, p + 4, 0, p + 3);
    $display("Test pwm done");
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_PWM, 1'b0, 1'b0));
    bus(tot_pkg::PERIOD_OFS, 1'b1, d + 10);
    bus(tot_pkg::DUTY_OFS, 1'b1, d);
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_ONESHOT, 1'b1, 1'b0));
    rd(tot_pkg::COUNT_OFS, {16'h0, tot_pkg::CNT_IDLE});
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_ONESHOT, 1'b1, 1'b1));
    wait_on(1, 1, n);
    wait_on(0, 1, n);
    check(n, d);
    pin();
    wait_on(0, 0, n);
    // The pin() call took one sample of the pulse
    check(n + 1, 11);
    check(period_match_irq, 1'b1);
    repeat (12) @(negedge pclk);
    check(toggle_out, 1'b0);
    rd(tot_pkg::COUNT_OFS, {16'h0, tot_pkg::CNT_IDLE});
    pin();
    wait_on(0, 1, n);
    check(n <= 20, 1'b1);
    wait_on(0, 0, n);
    $display("Test oneshot done");
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_ONESHOT, 1'b0, 1'b0));
    bus(tot_pkg::PERIOD_OFS, 1'b1, 40);
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_EXT, 1'b1, 1'b0));
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_EXT, 1'b1, 1'b1));
    wait_on(0, 1, n);
    wait_on(0, 0, n);
    check(n, d);
    pin();
    wait_on(0, 1, n);
    check(n < 30, 1'b1);
    wait_on(0, 0, n);
    check(n, d);
    bus(tot_pkg::CTRL_OFS, 1'b1, ctl(tot_pkg::MODE_EXT, 1'b0, 1'b0));
    $display("Test ext done");
    check(exp_q.size(), 0);
    print_verdict();
  end
endmodule
